/* src/fprs_pkg.sv */
// Package: constants and types for the front panel run/reset sequencer
// Functional notes
// - In ERROR state the fault lamp blinks with a one second period.
// - In STOP state the halt indication lamp is lit steadily.
// - In RUN the run lamp clears after input capture, sets before output send.
// - Switch in halt position suspends cyclic program execution.
// - Switch in run position gives normal cyclic program execution.
// - Reset position starts a reset; RUN follows when switch returns to run.
// - Reset held over long press time lights the acknowledge lamp; operator releases.
// - After long press, one press selects function one, two presses function two.
// - Extended function one erases all battery-backed data blocks.
// - Extended function two erases project and loads the read-only memory project.
// - Acknowledge lamp goes off, then flashes once or twice to confirm selection.
// - After selection window, lamp steady for confirm window; a press activates.
// - Short press or expired windows without activation give an ordinary reset.
// - Low battery raises a controller error, module code 120, error number 1.
package fprs_pkg;
    localparam int CLK_HZ = 50_000_000;
    // Times in milliseconds
    localparam int BLINK_PERIOD_MS = 1000;
    localparam int LONG_PRESS_MS = 5000;
    localparam int SELECT_WIN_MS = 20000;
    localparam int CONFIRM_WIN_MS = 10000;
    localparam int DEBOUNCE_MS = 20;
    localparam int FLASH_MS = 250;
    // Millisecond tick divider
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam logic [15:0] MS_DIV_LAST = 16'(MS_CYCLES - 1);
    localparam logic [15:0] BLINK_HALF_MS = 16'(BLINK_PERIOD_MS / 2);
    localparam logic [15:0] DEBOUNCE_LAST = 16'(DEBOUNCE_MS - 1);
    localparam logic [15:0] FLASH_LAST = 16'(FLASH_MS - 1);
    // Error report
    localparam logic [7:0] ERR_MODULE_BATT = 8'h78;
    localparam logic [7:0] ERR_NUMBER_BATT = 8'h01;
    // Controller operating state
    typedef enum {ST_STOP, ST_RUN, ST_ERROR, ST_RESET} fprs_ctl_type;
    // Switch position, one-hot decoded
    typedef struct packed {
        logic halt;
        logic run;
        logic rst;
    } fprs_sw_type;
    // Error report carried together
    typedef struct packed {
        logic valid;
        logic [7:0] module_code;
        logic [7:0] number;
    } fprs_err_type;
endpackage

/* src/fprs_debounce.sv */
// Debounce filter for one switch contact
`timescale 1ns/1ns
module fprs_debounce (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_NRST,
    // Millisecond tick and raw contact
    input wire logic i_tick,
    input wire logic i_raw,
    // Filtered level
    output logic o_level
);
    logic [15:0] cnt_ff;
    logic level_ff;

    // Accept a new level only after it is stable for the debounce time
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cnt_ff <= 16'h0000;
            level_ff <= 1'b0;
        end else if (i_raw == level_ff) begin
            cnt_ff <= 16'h0000;
        end else if (i_tick) begin
            if (cnt_ff == fprs_pkg::DEBOUNCE_LAST) begin
                level_ff <= i_raw;
                cnt_ff <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

    assign o_level = level_ff;
endmodule

/* src/fprs_top.sv */
// Front panel supervisor: lamps, run/stop/reset switch and extended reset
`timescale 1ns/1ns
module fprs_top #(
    parameter logic [15:0] LONG_PRESS_TICKS = 16'(fprs_pkg::LONG_PRESS_MS),
    parameter logic [15:0] SELECT_TICKS = 16'(fprs_pkg::SELECT_WIN_MS),
    parameter logic [15:0] CONFIRM_TICKS = 16'(fprs_pkg::CONFIRM_WIN_MS),
    parameter logic [15:0] MS_DIV_LAST = fprs_pkg::MS_DIV_LAST
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_NRST,
    // Switch contacts, high when in that position
    input wire logic I_SW_HALT,
    input wire logic I_SW_RUN,
    input wire logic I_SW_RESET,
    // Controller cycle events and fault sources
    input wire logic I_INPUT_IMAGE_DONE,
    input wire logic I_OUTPUT_IMAGE_START,
    input wire logic I_FAULT,
    input wire logic I_BATT_LOW,
    input wire logic I_ERASE_DONE,
    // Lamps
    output logic O_FAULT_LAMP,
    output logic O_HALT_INDICATION,
    output logic O_RUN_INDICATION,
    output logic O_HOLD_ACK_LAMP,
    // Controller commands
    output logic O_CYCLIC_ENABLE,
    output logic O_CTL_RESET,
    output logic O_ERASE_DATA_BLOCKS,
    output logic O_LOAD_ROM_PROJECT,
    // Error report
    output logic O_ERR_VALID,
    output logic [7:0] O_ERR_MODULE,
    output logic [7:0] O_ERR_NUMBER
);
    typedef enum {XS_IDLE, XS_PRESS, XS_HELD, XS_SELECT, XS_CONFIRM, XS_EXEC} fprs_xs_type;

    logic [15:0] div_ff;
    logic tick;
    fprs_pkg::fprs_sw_type sw;
    logic rst_prev_ff;
    logic rst_rise;
    logic rst_fall;
    logic [15:0] blink_ff;
    logic blink_on_ff;
    fprs_pkg::fprs_ctl_type ctl_ff;
    fprs_pkg::fprs_ctl_type nxt_ctl;
    fprs_xs_type xs_ff;
    logic [15:0] tmr_ff;
    logic [1:0] sel_ff;
    logic [2:0] flash_ph_ff;
    logic [15:0] flash_cnt_ff;
    logic run_lamp_ff;
    logic hold_ack;
    logic ctl_reset_ff;
    logic erase_ff;
    logic rom_ff;
    fprs_pkg::fprs_err_type err_ff;
    logic reset_req;

    // Millisecond tick divider
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            div_ff <= 16'h0000;
        end else if (div_ff == MS_DIV_LAST) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end
    assign tick = (div_ff == MS_DIV_LAST);

    // Debounced switch contacts
    fprs_debounce u_db_halt (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .i_tick(tick),
        .i_raw(I_SW_HALT), .o_level(sw.halt));
    fprs_debounce u_db_run (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .i_tick(tick),
        .i_raw(I_SW_RUN), .o_level(sw.run));
    fprs_debounce u_db_rst (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .i_tick(tick),
        .i_raw(I_SW_RESET), .o_level(sw.rst));

    // Reset contact edge detection on the filtered level
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_prev_ff <= 1'b0;
        end else begin
            rst_prev_ff <= sw.rst;
        end
    end
    assign rst_rise = sw.rst && !rst_prev_ff;
    assign rst_fall = !sw.rst && rst_prev_ff;

    // Fault lamp blink: half period on, half period off
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            blink_ff <= 16'h0000;
            blink_on_ff <= 1'b0;
        end else if (ctl_ff != fprs_pkg::ST_ERROR) begin
            blink_ff <= 16'h0000;
            blink_on_ff <= 1'b1;
        end else if (tick) begin
            if (blink_ff == fprs_pkg::BLINK_HALF_MS - 16'h0001) begin
                blink_ff <= 16'h0000;
                blink_on_ff <= !blink_on_ff;
            end else begin
                blink_ff <= blink_ff + 16'h0001;
            end
        end
    end

    // Extended reset sequencer
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            xs_ff <= XS_IDLE;
            tmr_ff <= 16'h0000;
            sel_ff <= 2'b00;
            ctl_reset_ff <= 1'b0;
            erase_ff <= 1'b0;
            rom_ff <= 1'b0;
        end else begin
            ctl_reset_ff <= 1'b0;
            case (xs_ff)
                XS_IDLE: begin
                    tmr_ff <= 16'h0000;
                    sel_ff <= 2'b00;
                    if (rst_rise) begin
                        xs_ff <= XS_PRESS;
                    end
                end
                XS_PRESS: begin
                    if (!sw.rst) begin
                        ctl_reset_ff <= 1'b1;
                        xs_ff <= XS_IDLE;
                    end else if (tick) begin
                        if (tmr_ff == LONG_PRESS_TICKS) begin
                            xs_ff <= XS_HELD;
                        end else begin
                            tmr_ff <= tmr_ff + 16'h0001;
                        end
                    end
                end
                XS_HELD: begin
                    tmr_ff <= 16'h0000;
                    if (rst_fall) begin
                        xs_ff <= XS_SELECT;
                    end
                end
                XS_SELECT: begin
                    if (rst_rise && sel_ff != 2'b10) begin
                        sel_ff <= sel_ff + 2'b01;
                    end
                    if (tick) begin
                        if (tmr_ff == SELECT_TICKS - 16'h0001) begin
                            tmr_ff <= 16'h0000;
                            xs_ff <= XS_CONFIRM;
                        end else begin
                            tmr_ff <= tmr_ff + 16'h0001;
                        end
                    end
                end
                XS_CONFIRM: begin
                    if (rst_rise && sel_ff != 2'b00) begin
                        erase_ff <= (sel_ff == 2'b01) || (sel_ff == 2'b10);
                        rom_ff <= (sel_ff == 2'b10);
                        xs_ff <= XS_EXEC;
                    end else if (tick) begin
                        if (tmr_ff == CONFIRM_TICKS - 16'h0001) begin
                            ctl_reset_ff <= 1'b1;
                            xs_ff <= XS_IDLE;
                        end else begin
                            tmr_ff <= tmr_ff + 16'h0001;
                        end
                    end
                end
                XS_EXEC: begin
                    if (I_ERASE_DONE) begin
                        erase_ff <= 1'b0;
                        rom_ff <= 1'b0;
                        ctl_reset_ff <= 1'b1;
                        xs_ff <= XS_IDLE;
                    end
                end
                default: begin
                    xs_ff <= XS_IDLE;
                end
            endcase
        end
    end

    // Confirmation flash phase counter: off, on, off, on, off
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            flash_ph_ff <= 3'h0;
            flash_cnt_ff <= 16'h0000;
        end else if (xs_ff != XS_SELECT || rst_rise) begin
            flash_ph_ff <= 3'h0;
            flash_cnt_ff <= 16'h0000;
        end else if (tick && flash_ph_ff != 3'h5) begin
            if (flash_cnt_ff == fprs_pkg::FLASH_LAST) begin
                flash_cnt_ff <= 16'h0000;
                flash_ph_ff <= flash_ph_ff + 3'h1;
            end else begin
                flash_cnt_ff <= flash_cnt_ff + 16'h0001;
            end
        end
    end

    // Acknowledge lamp per sequencer stage; no flash until something is selected
    always_comb begin
        hold_ack = 1'b0;
        case (xs_ff)
            XS_HELD: hold_ack = 1'b1;
            XS_SELECT: hold_ack = (sel_ff != 2'b00) && ((flash_ph_ff == 3'h1) ||
                ((flash_ph_ff == 3'h3) && (sel_ff == 2'b10)));
            XS_CONFIRM: hold_ack = 1'b1;
            default: hold_ack = 1'b0;
        endcase
    end

    // Controller state from switch, fault and reset sequence
    assign reset_req = (xs_ff != XS_IDLE) || sw.rst;
    always_comb begin
        nxt_ctl = ctl_ff;
        if (I_FAULT || err_ff.valid) begin
            nxt_ctl = fprs_pkg::ST_ERROR;
        end else if (reset_req || ctl_reset_ff) begin
            nxt_ctl = fprs_pkg::ST_RESET;
        end else if (sw.halt) begin
            nxt_ctl = fprs_pkg::ST_STOP;
        end else if (sw.run) begin
            nxt_ctl = fprs_pkg::ST_RUN;
        end
    end
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ctl_ff <= fprs_pkg::ST_STOP;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end

    // Run lamp follows the scan cycle
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            run_lamp_ff <= 1'b0;
        end else if (ctl_ff != fprs_pkg::ST_RUN) begin
            run_lamp_ff <= 1'b0;
        end else if (I_OUTPUT_IMAGE_START) begin
            run_lamp_ff <= 1'b1;
        end else if (I_INPUT_IMAGE_DONE) begin
            run_lamp_ff <= 1'b0;
        end
    end

    // Battery low error, sticky until power-on reset
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            err_ff <= '0;
        end else if (I_BATT_LOW) begin
            err_ff.valid <= 1'b1;
            err_ff.module_code <= fprs_pkg::ERR_MODULE_BATT;
            err_ff.number <= fprs_pkg::ERR_NUMBER_BATT;
        end
    end

    // Outputs
    assign O_FAULT_LAMP = (ctl_ff == fprs_pkg::ST_ERROR) && blink_on_ff;
    assign O_HALT_INDICATION = (ctl_ff == fprs_pkg::ST_STOP);
    assign O_RUN_INDICATION = run_lamp_ff;
    assign O_HOLD_ACK_LAMP = hold_ack;
    assign O_CYCLIC_ENABLE = (ctl_ff == fprs_pkg::ST_RUN);
    assign O_CTL_RESET = (ctl_ff == fprs_pkg::ST_RESET);
    assign O_ERASE_DATA_BLOCKS = erase_ff;
    assign O_LOAD_ROM_PROJECT = rom_ff;
    assign O_ERR_VALID = err_ff.valid;
    assign O_ERR_MODULE = err_ff.module_code;
    assign O_ERR_NUMBER = err_ff.number;
endmodule

/* tb/fprs_top_checker.sv */
// Port checker for the front panel sequencer
`timescale 1ns/1ns
module fprs_top_checker #(
    parameter logic [15:0] MS_DIV_LAST = fprs_pkg::MS_DIV_LAST
) (
    // Clock, reset and inputs
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire logic I_INPUT_IMAGE_DONE,
    input wire logic I_OUTPUT_IMAGE_START,
    input wire logic I_BATT_LOW,
    input wire logic I_ERASE_DONE,
    // Outputs
    input wire logic O_FAULT_LAMP,
    input wire logic O_HALT_INDICATION,
    input wire logic O_RUN_INDICATION,
    input wire logic O_CYCLIC_ENABLE,
    input wire logic O_CTL_RESET,
    input wire logic O_ERASE_DATA_BLOCKS,
    input wire logic O_LOAD_ROM_PROJECT,
    input wire logic O_ERR_VALID,
    input wire logic [7:0] O_ERR_MODULE,
    input wire logic [7:0] O_ERR_NUMBER
);
    localparam int HALF = int'(fprs_pkg::BLINK_HALF_MS) * (int'(MS_DIV_LAST) + 1);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    logic [31:0] on_ff;
    logic fell_ff;
    // Lit length of the fault lamp; the first phase may be cut short
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            on_ff <= 32'h0000_0000;
            fell_ff <= 1'b0;
        end else begin
            on_ff <= O_FAULT_LAMP ? on_ff + 32'h0000_0001 : 32'h0000_0000;
            // Only falls inside the battery error state arm the phase check
            fell_ff <= fell_ff | (O_ERR_VALID && !O_FAULT_LAMP && on_ff != 32'h0000_0000);
        end
    end
    property p_halt; O_HALT_INDICATION |-> !O_CYCLIC_ENABLE && !O_FAULT_LAMP; endproperty
    a_halt: assert property (p_halt) else $error("halt lamp with run or fault");
    property p_run_set;
        O_CYCLIC_ENABLE && I_OUTPUT_IMAGE_START ##1 O_CYCLIC_ENABLE |-> O_RUN_INDICATION;
    endproperty
    a_run_set: assert property (p_run_set) else $error("run lamp not set");
    property p_run_clr;
        O_CYCLIC_ENABLE && I_INPUT_IMAGE_DONE && !I_OUTPUT_IMAGE_START ##1 O_CYCLIC_ENABLE
            |-> !O_RUN_INDICATION;
    endproperty
    a_run_clr: assert property (p_run_clr) else $error("run lamp not cleared");
    property p_err_code; O_ERR_VALID |-> O_ERR_MODULE == 8'h78 && O_ERR_NUMBER == 8'h01; endproperty
    a_err_code: assert property (p_err_code) else $error("wrong error code");
    property p_err_keep; O_ERR_VALID |=> O_ERR_VALID; endproperty
    a_err_keep: assert property (p_err_keep) else $error("error report dropped");
    property p_batt; I_BATT_LOW |-> ##[0:2] O_ERR_VALID; endproperty
    a_batt: assert property (p_batt) else $error("battery error missing");
    property p_err_state; O_ERR_VALID |-> ##2 !O_CYCLIC_ENABLE && !O_HALT_INDICATION; endproperty
    a_err_state: assert property (p_err_state) else $error("error state not taken");
    property p_blink; $fell(O_FAULT_LAMP) && O_ERR_VALID && fell_ff |-> on_ff == HALF; endproperty
    a_blink: assert property (p_blink) else $error("fault lamp phase length wrong");
    property p_rom; O_LOAD_ROM_PROJECT |-> O_ERASE_DATA_BLOCKS; endproperty
    a_rom: assert property (p_rom) else $error("project load without erase");
    property p_start; $rose(O_ERASE_DATA_BLOCKS) |-> O_CTL_RESET && !O_CYCLIC_ENABLE; endproperty
    a_start: assert property (p_start) else $error("erase outside reset");
    property p_done;
        O_ERASE_DATA_BLOCKS && I_ERASE_DONE |=> !O_ERASE_DATA_BLOCKS && !O_LOAD_ROM_PROJECT;
    endproperty
    a_done: assert property (p_done) else $error("erase not ended");
    c_rom: cover property ($rose(O_LOAD_ROM_PROJECT));
    c_err: cover property ($rose(O_ERR_VALID));
    c_blink: cover property ($fell(O_FAULT_LAMP) && fell_ff);
endmodule
bind fprs_top fprs_top_checker #(.MS_DIV_LAST(MS_DIV_LAST)) fprs_top_checker_i (
    .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_INPUT_IMAGE_DONE(I_INPUT_IMAGE_DONE),
    .I_OUTPUT_IMAGE_START(I_OUTPUT_IMAGE_START), .I_BATT_LOW(I_BATT_LOW),
    .I_ERASE_DONE(I_ERASE_DONE), .O_FAULT_LAMP(O_FAULT_LAMP),
    .O_HALT_INDICATION(O_HALT_INDICATION), .O_RUN_INDICATION(O_RUN_INDICATION),
    .O_CYCLIC_ENABLE(O_CYCLIC_ENABLE), .O_CTL_RESET(O_CTL_RESET),
    .O_ERASE_DATA_BLOCKS(O_ERASE_DATA_BLOCKS), .O_LOAD_ROM_PROJECT(O_LOAD_ROM_PROJECT),
    .O_ERR_VALID(O_ERR_VALID), .O_ERR_MODULE(O_ERR_MODULE), .O_ERR_NUMBER(O_ERR_NUMBER)
);

/* tb/fprs_operator.sv */
// Operator at the panel switch; contacts chatter after each move
`timescale 1ns/1ns
module fprs_operator (
    // Clock and wanted position: 0 halt, 1 run, 2 reset
    input wire logic i_clk,
    input wire logic [1:0] i_pos,
    // Switch contacts
    output fprs_pkg::fprs_sw_type o_sw
);
    logic [1:0] cur = 2'h0;
    logic [3:0] bounce = 4'h0;
    logic on;
    // A new position chatters for some cycles before it settles
    always @(negedge i_clk) begin
        if (i_pos != cur) begin
            cur <= i_pos;
            bounce <= 4'hb;
        end else if (bounce != 4'h0) begin
            bounce <= bounce - 4'h1;
        end
    end
    // Only the contact of the current position closes
    assign on = (bounce == 4'h0) | bounce[0];
    assign o_sw = {cur == 2'h0, cur == 2'h1, cur == 2'h2} & {3{on}};
endmodule

/* tb/fprs_top_tb_top.sv */
// Bench for the front panel sequencer, with a run lamp reference model
`timescale 1ns/1ns
module fprs_top_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] pos = 2'h0;
    logic img_in = 1'b0;
    logic img_out = 1'b0;
    logic fault = 1'b0;
    logic batt = 1'b0;
    logic done = 1'b0;
    logic [7:0] seed = 8'h25;
    logic fl, hl, rl, ack, cyc, crst, era, rom, ev;
    logic [7:0] em, en;
    fprs_pkg::fprs_sw_type sw;
    int err_total = 0;
    int cmp_count = 0;
    int exp_run;
    int rises;
    int on_t;
    int off_t;
    wire [4:0] mon = {fl, ack, cyc, crst, era};
    fprs_top #(
        .LONG_PRESS_TICKS(16'h0020), .SELECT_TICKS(16'h05dc),
        .CONFIRM_TICKS(16'h012c), .MS_DIV_LAST(16'h0009)
    ) fprs_top_i (
        .I_MCLK(clk), .I_NRST(nrst), .I_SW_HALT(sw.halt), .I_SW_RUN(sw.run),
        .I_SW_RESET(sw.rst), .I_INPUT_IMAGE_DONE(img_in), .I_OUTPUT_IMAGE_START(img_out),
        .I_FAULT(fault), .I_BATT_LOW(batt), .I_ERASE_DONE(done),
        .O_FAULT_LAMP(fl), .O_HALT_INDICATION(hl), .O_RUN_INDICATION(rl),
        .O_HOLD_ACK_LAMP(ack), .O_CYCLIC_ENABLE(cyc), .O_CTL_RESET(crst),
        .O_ERASE_DATA_BLOCKS(era), .O_LOAD_ROM_PROJECT(rom),
        .O_ERR_VALID(ev), .O_ERR_MODULE(em), .O_ERR_NUMBER(en)
    );
    fprs_operator fprs_operator_i (.i_clk(clk), .i_pos(pos), .o_sw(sw));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("Counts: compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait for one watched output to reach a level
    task automatic wait_mon(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (mon[k] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (mon[k] !== v) begin
            chk(mon[k], v);
            final_report();
        end
    endtask
    // Long press, n selections, then activation in the confirm window
    task automatic ext_reset(input int n);
        pos = 2'h2;
        wait_mon(3, 1'b1, 2000);
        pos = 2'h1;
        waitc(600);
        rises = 0;
        for (int i = 0; i < n; i++) begin
            pos = 2'h2;
            waitc(400);
            pos = 2'h1;
            waitc(400);
        end
        waitc(10200);
        chk(16'(rises), 16'(n));
        wait_mon(3, 1'b1, 6000);
        pos = 2'h2;
        wait_mon(0, 1'b1, 1000);
        chk(rom, n == 2);
        pos = 2'h1;
        waitc(50);
        done = 1'b1;
        waitc(1);
        done = 1'b0;
        wait_mon(0, 1'b0, 10);
        chk(rom, 1'b0);
        wait_mon(2, 1'b1, 2000);
        $display("Test done: extended function %0d", n);
    endtask
    // Clock
    initial begin
        forever #10 clk = ~clk;
    end
    // Acknowledge lamp flashes
    always @(posedge ack) rises++;
    // Main sequence
    initial begin
        waitc(5);
        nrst = 1'b1;
        chk(hl, 1'b1);
        chk({fl, rl, ack, cyc, crst, era, rom, ev}, 16'h0000);
        waitc(300);
        chk(cyc, 1'b0);
        pos = 2'h1;
        wait_mon(2, 1'b1, 600);
        chk(hl, 1'b0);
        $display("Test done: halt and run");
        exp_run = 1;
        img_out = 1'b1;
        repeat (64) begin
            waitc(1);
            chk(rl, exp_run[0]);
            seed = lfsr(seed);
            img_in = seed[0];
            img_out = seed[1] & seed[2];
            exp_run = img_out ? 1 : (img_in ? 0 : exp_run);
        end
        img_in = 1'b0;
        img_out = 1'b0;
        $display("Test done: run lamp");
        pos = 2'h2;
        wait_mon(1, 1'b1, 600);
        chk(cyc, 1'b0);
        waitc(50);
        pos = 2'h1;
        wait_mon(2, 1'b1, 800);
        chk(ack, 1'b0);
        $display("Test done: short reset");
        // Controller fault forces the error state while it stands
        fault = 1'b1;
        waitc(2);
        chk({fl, cyc, hl}, 16'h0004);
        fault = 1'b0;
        wait_mon(2, 1'b1, 10);
        $display("Test done: fault");
        ext_reset(1);
        ext_reset(2);
        // Long press, no selection, both windows run out
        pos = 2'h2;
        wait_mon(3, 1'b1, 2000);
        pos = 2'h1;
        wait_mon(3, 1'b0, 600);
        wait_mon(3, 1'b1, 16000);
        wait_mon(3, 1'b0, 3100);
        chk(era, 1'b0);
        wait_mon(2, 1'b1, 10);
        $display("Test done: windows expired");
        batt = 1'b1;
        waitc(1);
        batt = 1'b0;
        waitc(3);
        chk({em, en}, 16'h7801);
        chk(ev, 1'b1);
        chk({cyc, hl}, 16'h0000);
        wait_mon(4, 1'b0, 6000);
        wait_mon(4, 1'b1, 6000);
        on_t = 0;
        off_t = 0;
        while (fl === 1'b1 && on_t < 6000) begin
            @(negedge clk);
            on_t++;
        end
        while (fl === 1'b0 && off_t < 6000) begin
            @(negedge clk);
            off_t++;
        end
        chk(16'(on_t), 16'(off_t));
        chk(16'(on_t + off_t), 16'h2710);
        nrst = 1'b0;
        waitc(2);
        chk({ev, hl}, 16'h0001);
        $display("Test done: battery error");
        final_report();
    end
endmodule
